// >>> inc/relay_pkg.sv
// shared constants and types for the relay output controller
package relay_pkg;
    localparam int NUM_RELAYS = 4;
    localparam int RELAYS_PER_MODULE = 2;
    localparam int NUM_MODULES = NUM_RELAYS / RELAYS_PER_MODULE;
    localparam int NUM_SETPOINTS = 4;
    localparam int VALUE_W = 16;
    localparam int WIDTH_W = 8;
    localparam int TIME_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_BYTES = 4;
    localparam int CFG_FIELD_W = 8;
    localparam int RELEASE_LSB = 4;
    localparam int STATE_COIL_LSB = 4;
    localparam int STATE_TRIG_LSB = 8;
    localparam int STATE_PRESENT_LSB = 12;
    localparam logic [WIDTH_W-1:0] PULSE_WIDTH_RESET = 8'h02;
    localparam logic [VALUE_W-1:0] THRESHOLD_RESET = 16'hffff;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_RELAY_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SETPOINT_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD0 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_REMOTE = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PULSE_WIDTH = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_RELAY_STATE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_EVENT_TIME = 8'h30;

    typedef enum logic [1:0] {
        MODE_LATCHED = 2'h0,
        MODE_UNLATCHED = 2'h1,
        MODE_PULSE = 2'h2,
        MODE_KYZ = 2'h3
    } relay_mode_t;

    typedef enum logic [1:0] {
        SRC_SETPOINT = 2'h0,
        SRC_REMOTE = 2'h1,
        SRC_ENERGY = 2'h2,
        SRC_INTERVAL = 2'h3
    } relay_src_t;

    typedef enum logic [1:0] {
        TRIG_OFF = 2'h0,
        TRIG_ABOVE = 2'h1,
        TRIG_DIN_EDGE = 2'h2,
        TRIG_DIAG = 2'h3
    } trig_kind_t;

    typedef struct packed {
        relay_src_t source;
        logic invert;
        relay_mode_t mode;
    } relay_cfg_t;

    typedef struct packed {
        logic [1:0] input_sel;
        trig_kind_t kind;
    } setpoint_cfg_t;

    typedef struct packed {
        logic [NUM_SETPOINTS-1:0][VALUE_W-1:0] analog;
        logic [NUM_SETPOINTS-1:0] din;
        logic diag;
    } meas_t;

    typedef struct packed {
        logic [TIME_W-1:0] stamp;
        logic [1:0] source;
        logic [VALUE_W-1:0] value;
    } event_rec_t;
endpackage

// >>> rtl/setpoint_trigger.sv
// one setpoint of the logic controller, evaluated each half cycle
`timescale 1ns/1ps
module setpoint_trigger (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic half_cycle_tick,
    input wire relay_pkg::setpoint_cfg_t cfg,
    input wire logic [relay_pkg::VALUE_W-1:0] threshold,
    input wire relay_pkg::meas_t meas,
    output logic trig,
    output logic trig_event,
    output logic [relay_pkg::VALUE_W-1:0] trig_value
);
    import relay_pkg::*;

    logic next_cond;
    logic [VALUE_W-1:0] sample;
    logic [NUM_SETPOINTS-1:0] din_seen;

    // condition for this half cycle
    always_comb begin
        next_cond = 1'b0;
        sample = '0;
        case (cfg.kind)
            TRIG_ABOVE: begin
                sample = meas.analog[cfg.input_sel];
                next_cond = sample > threshold;
            end
            TRIG_DIN_EDGE: begin
                sample = VALUE_W'(meas.din[cfg.input_sel]);
                next_cond = meas.din[cfg.input_sel] != din_seen[cfg.input_sel];
            end
            TRIG_DIAG: begin
                sample = VALUE_W'(meas.diag);
                next_cond = meas.diag;
            end
            default: begin
                next_cond = 1'b0;
            end
        endcase
    end

    // latched once per tick so the answer is ready within the half cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            trig <= 1'b0;
            trig_event <= 1'b0;
            trig_value <= '0;
            din_seen <= '0;
        end else begin
            trig_event <= half_cycle_tick && next_cond && !trig;
            if (half_cycle_tick) begin
                trig <= next_cond;
                din_seen <= meas.din;
                if (next_cond && !trig) begin
                    trig_value <= sample;
                end
            end
        end
    end

    trig_on_tick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(half_cycle_tick) |-> $stable(trig))
        else $error("setpoint trigger moved between ticks");

    above_trips_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        half_cycle_tick && cfg.kind == TRIG_ABOVE && meas.analog[cfg.input_sel] > threshold
        |=> trig)
        else $error("threshold crossing missed");
endmodule // setpoint_trigger

// >>> rtl/relay_channel.sv
// one relay output: mode sequencing, inversion and coil drive
`timescale 1ns/1ps
module relay_channel (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic half_cycle_tick,
    input wire relay_pkg::relay_cfg_t cfg,
    input wire logic request,
    input wire logic release_cmd,
    input wire logic [relay_pkg::WIDTH_W-1:0] pulse_width,
    output logic operated,
    output logic coil
);
    import relay_pkg::*;

    logic req_q;
    logic pend;
    logic rel_pend;
    logic take;
    logic req_rise;
    logic [WIDTH_W-1:0] left;

    assign req_rise = request && !req_q;
    // a pulse in progress holds back further requests
    assign take = half_cycle_tick && !(cfg.mode == MODE_PULSE && left != '0);

    // remember request edges and releases between ticks; an edge that arrives
    // on the tick itself is used there and not kept, or it would act twice
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q <= 1'b0;
            pend <= 1'b0;
            rel_pend <= 1'b0;
        end else begin
            req_q <= request;
            if (req_rise && !take) begin
                pend <= 1'b1;
            end else if (take) begin
                pend <= 1'b0;
            end
            if (release_cmd) begin
                rel_pend <= 1'b1;
            end else if (half_cycle_tick) begin
                rel_pend <= 1'b0;
            end
        end
    end

    // contact state is refreshed only on the half-cycle tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            operated <= 1'b0;
            left <= '0;
        end else if (half_cycle_tick) begin
            case (cfg.mode)
                MODE_LATCHED: begin
                    if (request) begin
                        operated <= 1'b1;
                    end else if (rel_pend || release_cmd) begin
                        operated <= 1'b0;
                    end
                    left <= '0;
                end
                MODE_UNLATCHED: begin
                    operated <= request;
                    left <= '0;
                end
                MODE_PULSE: begin
                    if (left > WIDTH_W'(1)) begin
                        left <= left - WIDTH_W'(1);
                    end else if (left == WIDTH_W'(1)) begin
                        left <= '0;
                        operated <= 1'b0;
                    end else if ((pend || req_rise) && pulse_width != '0) begin
                        left <= pulse_width;
                        operated <= 1'b1;
                    end else begin
                        operated <= 1'b0;
                    end
                end
                MODE_KYZ: begin
                    if (pend || req_rise) begin
                        operated <= !operated;
                    end
                    left <= '0;
                end
                default: begin
                    operated <= 1'b0;
                    left <= '0;
                end
            endcase
        end
    end

    // failsafe: inverted relays hold the coil energized while idle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            coil <= 1'b0;
        end else begin
            coil <= operated ^ cfg.invert;
        end
    end

    refresh_tick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(half_cycle_tick) |-> $stable(operated))
        else $error("relay changed outside a tick");

    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        half_cycle_tick && cfg.mode == MODE_LATCHED && operated && !rel_pend && !release_cmd
        |=> operated)
        else $error("latched relay dropped without release");

    unlatched_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        half_cycle_tick && cfg.mode == MODE_UNLATCHED |=> operated == $past(request))
        else $error("unlatched relay did not follow trigger");

    kyz_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        half_cycle_tick && cfg.mode == MODE_KYZ && pend |=> operated != $past(operated))
        else $error("kyz relay did not toggle");

    failsafe_coil_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        half_cycle_tick && cfg.mode == MODE_LATCHED && request && $stable(cfg)
        |=> ##1 coil == !cfg.invert)
        else $error("coil polarity wrong for operated relay");
endmodule // relay_channel

// >>> rtl/relay_output_controller.sv
// relay output controller: registers, setpoints, relay channels, event log
`timescale 1ns/1ps
// What this block does
// - Up to four relays, two on each of two plug-in I/O modules.
// - Each relay state is refreshed once per line half cycle.
// - Every relay picks its own mode: latched, unlatched, pulse or KYZ.
// - Inverted relay keeps coil energized when idle, drops it when operated.
// - Relay driven by setpoint, remote command, energy or interval pulse.
// - Setpoint controller answers fast triggers within one half cycle.
// - Trigger on threshold exceeded or on a monitored input transition.
// - Controller can watch diagnostics and signal faults through a relay.
// - Each controller operation is logged with time, source and value.
// - Green indicator lit while the relay normally open contact is closed.
module relay_output_controller (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic half_cycle_tick,
    input wire logic [relay_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [relay_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [relay_pkg::DATA_W-1:0] reg_rdata,
    input wire relay_pkg::meas_t meas,
    input wire logic [relay_pkg::NUM_RELAYS-1:0] energy_pulse,
    input wire logic [relay_pkg::NUM_RELAYS-1:0] interval_pulse,
    input wire logic [relay_pkg::NUM_MODULES-1:0] dual_input_dual_output_module,
    output logic [relay_pkg::NUM_RELAYS-1:0] relay_coil,
    output logic [relay_pkg::NUM_RELAYS-1:0] relay_status_indicator,
    output logic event_valid,
    output relay_pkg::event_rec_t event_rec,
    output logic irq
);
    import relay_pkg::*;

    relay_cfg_t [NUM_RELAYS-1:0] relay_cfg;
    setpoint_cfg_t [NUM_SETPOINTS-1:0] sp_cfg;
    logic [NUM_SETPOINTS-1:0][VALUE_W-1:0] threshold;
    logic [NUM_SETPOINTS-1:0][VALUE_W-1:0] trig_value;
    logic [NUM_RELAYS-1:0] remote;
    logic [NUM_RELAYS-1:0] release_cmd;
    logic [WIDTH_W-1:0] pulse_width;
    logic [NUM_SETPOINTS-1:0] trig;
    logic [NUM_SETPOINTS-1:0] trig_event;
    logic [NUM_SETPOINTS-1:0] log_pend;
    logic [NUM_SETPOINTS-1:0] log_pick;
    logic [NUM_SETPOINTS-1:0] irq_status;
    logic [NUM_SETPOINTS-1:0] irq_enable;
    logic [NUM_SETPOINTS-1:0] irq_clear;
    logic [NUM_RELAYS-1:0] request;
    logic [NUM_RELAYS-1:0] operated;
    logic [NUM_RELAYS-1:0] coil_raw;
    logic [NUM_RELAYS-1:0] present;
    logic [TIME_W-1:0] half_cycles;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] pick_idx;

    // a relay on an empty slot is held off
    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            present[i] = dual_input_dual_output_module[i / RELAYS_PER_MODULE];
        end
    end

    // configuration registers written by software
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            relay_cfg <= '0;
            sp_cfg <= '0;
            pulse_width <= PULSE_WIDTH_RESET;
            irq_enable <= '0;
        end else if (reg_write) begin
            if (reg_addr == OFS_RELAY_CFG) begin
                for (int i = 0; i < NUM_RELAYS; i++) begin
                    relay_cfg[i] <= relay_cfg_t'(reg_wdata[i*CFG_FIELD_W +: $bits(relay_cfg_t)]);
                end
            end
            if (reg_addr == OFS_SETPOINT_CFG) begin
                for (int i = 0; i < NUM_SETPOINTS; i++) begin
                    sp_cfg[i] <= setpoint_cfg_t'(
                        reg_wdata[i*CFG_FIELD_W +: $bits(setpoint_cfg_t)]);
                end
            end
            if (reg_addr == OFS_PULSE_WIDTH) begin
                pulse_width <= reg_wdata[WIDTH_W-1:0];
            end
            if (reg_addr == OFS_IRQ_ENABLE) begin
                irq_enable <= reg_wdata[NUM_SETPOINTS-1:0];
            end
        end
    end

    // one threshold word per setpoint
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            threshold <= {NUM_SETPOINTS{THRESHOLD_RESET}};
        end else if (reg_write) begin
            for (int i = 0; i < NUM_SETPOINTS; i++) begin
                if (reg_addr == OFS_THRESHOLD0 + ADDR_W'(i * WORD_BYTES)) begin
                    threshold[i] <= reg_wdata[VALUE_W-1:0];
                end
            end
        end
    end

    // remote command: low bits set the operate level, upper bits release latches
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            remote <= '0;
            release_cmd <= '0;
        end else begin
            release_cmd <= '0;
            if (reg_write && reg_addr == OFS_REMOTE) begin
                remote <= reg_wdata[NUM_RELAYS-1:0];
                release_cmd <= reg_wdata[RELEASE_LSB +: NUM_RELAYS];
            end
        end
    end

    assign irq_clear = (reg_write && reg_addr == OFS_IRQ_CLEAR) ?
        reg_wdata[NUM_SETPOINTS-1:0] : '0;

    // sticky status; a new event in the clear cycle wins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | trig_event;
        end
    end

    assign irq = |(irq_status & irq_enable);

    // time base for the event records, in half cycles
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            half_cycles <= '0;
        end else if (half_cycle_tick) begin
            half_cycles <= half_cycles + TIME_W'(1);
        end
    end

    // setpoint logic controller
    for (genvar s = 0; s < NUM_SETPOINTS; s++) begin : g_sp
        setpoint_trigger u_sp (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .half_cycle_tick(half_cycle_tick),
            .cfg(sp_cfg[s]),
            .threshold(threshold[s]),
            .meas(meas),
            .trig(trig[s]),
            .trig_event(trig_event[s]),
            .trig_value(trig_value[s])
        );
    end

    // source selection for each relay
    always_comb begin
        for (int i = 0; i < NUM_RELAYS; i++) begin
            case (relay_cfg[i].source)
                SRC_SETPOINT: request[i] = trig[i];
                SRC_REMOTE: request[i] = remote[i];
                SRC_ENERGY: request[i] = energy_pulse[i];
                SRC_INTERVAL: request[i] = interval_pulse[i];
                default: request[i] = 1'b0;
            endcase
        end
    end

    for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_relay
        relay_channel u_relay (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .half_cycle_tick(half_cycle_tick),
            .cfg(relay_cfg[r]),
            .request(request[r]),
            .release_cmd(release_cmd[r]),
            .pulse_width(pulse_width),
            .operated(operated[r]),
            .coil(coil_raw[r])
        );
    end

    // coil and indicator drive; indicator shows the normally open contact
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            relay_coil <= '0;
            relay_status_indicator <= '0;
        end else begin
            relay_coil <= coil_raw & present;
            relay_status_indicator <= coil_raw & present;
        end
    end

    // fixed priority is cheap; a burst of four drains in four clocks, well inside a tick
    // lowest pending setpoint is logged first, one record per clock
    always_comb begin
        log_pick = '0;
        pick_idx = '0;
        for (int i = NUM_SETPOINTS - 1; i >= 0; i--) begin
            if (log_pend[i]) begin
                log_pick = '0;
                log_pick[i] = 1'b1;
                pick_idx = 2'(i);
            end
        end
    end

    // event records: several setpoints firing on one tick drain in turn
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            log_pend <= '0;
            event_valid <= 1'b0;
            event_rec <= '0;
        end else begin
            log_pend <= (log_pend & ~log_pick) | trig_event;
            event_valid <= |log_pend;
            if (|log_pend) begin
                event_rec.stamp <= half_cycles;
                event_rec.source <= pick_idx;
                event_rec.value <= trig_value[pick_idx];
            end
        end
    end

    // read mux; unmapped addresses and write-only words read zero
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            OFS_RELAY_CFG: begin
                for (int i = 0; i < NUM_RELAYS; i++) begin
                    next_rdata[i*CFG_FIELD_W +: $bits(relay_cfg_t)] = relay_cfg[i];
                end
            end
            OFS_SETPOINT_CFG: begin
                for (int i = 0; i < NUM_SETPOINTS; i++) begin
                    next_rdata[i*CFG_FIELD_W +: $bits(setpoint_cfg_t)] = sp_cfg[i];
                end
            end
            OFS_REMOTE: next_rdata[NUM_RELAYS-1:0] = remote;
            OFS_PULSE_WIDTH: next_rdata[WIDTH_W-1:0] = pulse_width;
            OFS_RELAY_STATE: begin
                next_rdata[NUM_RELAYS-1:0] = operated;
                next_rdata[STATE_COIL_LSB +: NUM_RELAYS] = coil_raw & present;
                next_rdata[STATE_TRIG_LSB +: NUM_SETPOINTS] = trig;
                next_rdata[STATE_PRESENT_LSB +: NUM_MODULES] = dual_input_dual_output_module;
            end
            OFS_IRQ_STATUS: next_rdata[NUM_SETPOINTS-1:0] = irq_status;
            OFS_IRQ_ENABLE: next_rdata[NUM_SETPOINTS-1:0] = irq_enable;
            OFS_EVENT_TIME: next_rdata = DATA_W'(half_cycles);
            default: begin
                for (int i = 0; i < NUM_SETPOINTS; i++) begin
                    if (reg_addr == OFS_THRESHOLD0 + ADDR_W'(i * WORD_BYTES)) begin
                        next_rdata[VALUE_W-1:0] = threshold[i];
                    end
                end
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? next_rdata : '0;
        end
    end

    event_logged_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        trig_event[0] |=> ##1 event_valid && event_rec.source == 2'h0
        && event_rec.value == $past(trig_value[0]))
        else $error("setpoint operation not logged");

    indicator_contact_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        relay_status_indicator == relay_coil)
        else $error("indicator does not match contact");

    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        trig_event[1] && irq_enable[1] && !(reg_write && reg_addr == OFS_IRQ_ENABLE) |=> irq)
        else $error("enabled event did not raise irq");

    // a read strobe's data stands for one cycle only
    rdata_one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(reg_read) |-> reg_rdata == '0)
        else $error("read data outside its cycle");

    // relays on an empty slot never drive their coil or light the indicator
    empty_slot_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (relay_coil & ~$past(present)) == '0)
        else $error("coil driven on an empty slot");

    // a clear never swallows an event landing in the same clock
    status_set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($past(trig_event) & ~irq_status) == '0)
        else $error("status bit lost its event");

    // bits cleared by software stay down unless a new event arrived
    status_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (irq_status & $past(irq_clear) & ~$past(trig_event)) == '0)
        else $error("status bit survived its clear");
endmodule // relay_output_controller

// >>> tb/relay_module_model.sv
// plug-in dual input dual output module model: slot fitting and relay contacts
`timescale 1ns/1ps
module relay_module_model (
    input wire logic [relay_pkg::NUM_RELAYS-1:0] relay_coil,
    input wire logic [relay_pkg::NUM_MODULES-1:0] fit_req,
    output logic [relay_pkg::NUM_MODULES-1:0] present,
    output logic [relay_pkg::NUM_RELAYS-1:0] contact_no
);
    // two relays per module, two slots; a module may be pulled at any time
    assign present = fit_req;
    // a normally open contact closes while its coil is energized; an empty slot closes nothing
    assign contact_no = relay_coil & {{2{present[1]}}, {2{present[0]}}};
endmodule // relay_module_model

// >>> tb/relay_output_controller_bench.sv
// self-checking bench for the relay output controller
`timescale 1ns/1ps
module relay_output_controller_bench;
    import relay_pkg::*;
    logic core_clk, rst_b, half_cycle_tick, reg_write, reg_read, event_valid, irq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    meas_t meas;
    logic [NUM_RELAYS-1:0] energy_pulse, interval_pulse, relay_coil, relay_status_indicator;
    logic [NUM_RELAYS-1:0] contact_no;
    logic [NUM_MODULES-1:0] fit_req, present;
    event_rec_t event_rec;
    int bad_count, num_checks, n;

    relay_output_controller u_relay_output_controller (.core_clk, .rst_b, .half_cycle_tick,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .meas, .energy_pulse,
        .interval_pulse, .dual_input_dual_output_module(present), .relay_coil,
        .relay_status_indicator, .event_valid, .event_rec, .irq);
    relay_module_model u_relay_module_model (.relay_coil, .fit_req, .present, .contact_no);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    // coil lands two cycles after the tick edge, so look one cycle later still
    task automatic coil_is(input logic [3:0] e);
        @(posedge core_clk);
        half_cycle_tick <= 1'b1;
        @(posedge core_clk);
        half_cycle_tick <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk({relay_status_indicator, contact_no, relay_coil}, {e, e, e});
    endtask

    task automatic pulse(input logic kyz);
        @(posedge core_clk);
        if (kyz) begin
            interval_pulse[3] <= 1'b1;
        end else begin
            energy_pulse[3] <= 1'b1;
        end
        @(posedge core_clk);
        interval_pulse <= '0;
        energy_pulse <= '0;
    endtask

    task automatic t_reset;
        rd(OFS_PULSE_WIDTH, 32'h0000_0002);
        rd(OFS_THRESHOLD0, 32'h0000_ffff);
        rd(OFS_RELAY_STATE, 32'h0000_3000);
        rd(OFS_IRQ_CLEAR, 32'h0000_0000);
        rd(8'hfc, 32'h0000_0000);
    endtask

    // relay0 unlatched, relay1 unlatched inverted, relay2 latched, all remote
    task automatic t_remote;
        wr(OFS_RELAY_CFG, 32'h0008_0d09);
        wr(OFS_REMOTE, 32'h0000_0001);
        coil_is(4'b0011);
        wr(OFS_REMOTE, 32'h0000_0006);
        repeat (5) @(posedge core_clk);
        #1;
        chk(relay_coil, 32'h3);
        coil_is(4'b0100);
        wr(OFS_REMOTE, 32'h0000_0000);
        coil_is(4'b0110);
        @(posedge core_clk);
        fit_req <= 2'b01;
        coil_is(4'b0010);
        @(posedge core_clk);
        fit_req <= 2'b11;
        wr(OFS_REMOTE, 32'h0000_0040);
        coil_is(4'b0010);
    endtask

    // relay3 as pulse from energy, then as toggle from interval
    task automatic t_pulse;
        wr(OFS_RELAY_CFG, 32'h1200_0000);
        pulse(1'b0);
        coil_is(4'b1000);
        coil_is(4'b1000);
        coil_is(4'b0000);
        wr(OFS_RELAY_CFG, 32'h1b00_0000);
        pulse(1'b1);
        coil_is(4'b1000);
        coil_is(4'b1000);
        pulse(1'b1);
        coil_is(4'b0000);
    endtask

    // threshold crossing logged two clocks after the tick is taken, raising irq
    task automatic t_setpoint;
        wr(OFS_THRESHOLD0, 32'h0000_0100);
        wr(OFS_SETPOINT_CFG, 32'h0000_0001);
        wr(OFS_IRQ_ENABLE, 32'h0000_0001);
        meas.analog[0] <= 16'h0200;
        @(posedge core_clk);
        half_cycle_tick <= 1'b1;
        @(posedge core_clk);
        half_cycle_tick <= 1'b0;
        for (n = 1; n < 8; n++) begin
            @(posedge core_clk);
            #1;
            if (event_valid === 1'b1) break;
        end
        chk(n, 2);
        chk({event_rec.source, event_rec.value}, 32'h0200);
        chk(event_rec.stamp, 32'h0000_000c);
        chk(irq, 1);
        wr(OFS_IRQ_CLEAR, 32'h0000_0001);
        #1;
        chk(irq, 0);
        rd(OFS_IRQ_STATUS, 32'h0000_0000);
        // diagnostic setpoint 1; relay0 operates from setpoint 0 at this tick
        wr(OFS_SETPOINT_CFG, 32'h0000_0301);
        meas.diag <= 1'b1;
        coil_is(4'b0001);
        rd(OFS_RELAY_STATE, 32'h0000_3311);
        rd(OFS_IRQ_STATUS, 32'h0000_0002);
    endtask

    initial begin
        rst_b = 1'b0;
        half_cycle_tick = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        meas = '0;
        energy_pulse = '0;
        interval_pulse = '0;
        fit_req = 2'b11;
        bad_count = 0;
        num_checks = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_remote();
        t_pulse();
        t_setpoint();
        close_out();
    end

    // whole run is about 120 cycles
    initial begin
        #40000;
        bad_count++;
        close_out();
    end
endmodule // relay_output_controller_bench
